// file: shared/scgc_params.svh
// Register offsets, field positions and reset values of the sleep clock gating block.
`ifndef SCGC_PARAMS_SVH
`define SCGC_PARAMS_SVH
`define SCGC_RUN_GATE_OFF      12'h100
`define SCGC_SLEEP_GATE_OFF    12'h110
`define SCGC_CLK_CFG_OFF       12'h060
`define SCGC_GATE_RESET        32'h0000_0040
`define SCGC_GATE_WMASK        32'h0001_0348
`define SCGC_CLK_CFG_RESET     32'h0000_0000
`define SCGC_CLK_CFG_WMASK     32'h0800_0000
`define SCGC_AUTO_GATE_BIT     27
`define SCGC_SAMPLER_BIT       16
`define SCGC_RATE_HI           9
`define SCGC_RATE_LO           8
`define SCGC_HIB_BIT           6
`define SCGC_WDOG_BIT          3
`define SCGC_RATE_MAX_RESET    2'h2
`endif

// file: shared/scgc_pkg.sv
// Types shared by the sleep clock gating block.
`default_nettype none
package scgc_pkg;
  typedef enum logic [2:0] {
    SCGC_IDLE   = 3'b001,
    SCGC_ACCESS = 3'b010,
    SCGC_DONE   = 3'b100
  } scgc_state_type;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } scgc_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } scgc_apb_rsp_type;

  typedef struct packed {
    logic       sampler_en;
    logic [1:0] sampler_rate;
    logic       hib_en;
    logic       wdog_en;
  } scgc_gate_type;

  typedef struct packed {
    logic [31:0]    run_gate;
    logic [31:0]    sleep_gate;
    logic [31:0]    clk_cfg;
    scgc_gate_type  gate;
    logic [31:0]    rdata;
    logic           slverr;
    scgc_state_type state;
  } scgc_regs_type;
endpackage : scgc_pkg
`default_nettype wire

// file: verilog/scgc_gate_ctrl.sv
// APB register block for run and sleep clock gating of the sampler, hibernate and watchdog units.
//
// Contract
// - Sleep register drives gating during Sleep
// - Sleep register used only with auto-gate
// - Set bit clocks unit, clear disables it
// - Access to unclocked unit returns fault
// - Gating registers reset to 0x00000040
// - Bit 16 enables sampler unit clock
// - Bits 9:8 select sampler rate
// - Bit 6 enables hibernate, resets set
// - Bit 3 enables watchdog clock
// - Reserved bits read zero, ignore writes
// - Sleep register at offset 0x110
// - Run register at 0x100, same layout
`default_nettype none
`include "scgc_params.svh"
module scgc_gate_ctrl
  import scgc_pkg::*;
#(
  parameter logic [1:0] RATE_MAX = `SCGC_RATE_MAX_RESET
) (
  input  wire logic        MCLK,
  input  wire logic        SRST,
  input  wire logic        CLK_EN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  input  wire logic        SLEEP_REQ,
  input  wire logic        SAMPLER_ACCESS,
  input  wire logic        WDOG_ACCESS,
  output var  logic        SAMPLER_CLK_EN,
  output var  logic [1:0]  SAMPLER_RATE,
  output var  logic        HIB_CLK_EN,
  output var  logic        WDOG_CLK_EN,
  output var  logic        SAMPLER_FAULT,
  output var  logic        WDOG_FAULT
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Keeps only the writable enable and rate bits so reserved positions always read zero.
  function automatic logic [31:0] scgc_mask_gate(input logic [31:0] v);
    scgc_mask_gate = v & `SCGC_GATE_WMASK;
  endfunction : scgc_mask_gate

  function automatic scgc_gate_type scgc_unpack(input logic [31:0] v);
    scgc_gate_type g;
    g.sampler_en   = v[`SCGC_SAMPLER_BIT];
    g.sampler_rate = v[`SCGC_RATE_HI:`SCGC_RATE_LO];
    g.hib_en       = v[`SCGC_HIB_BIT];
    g.wdog_en      = v[`SCGC_WDOG_BIT];
    scgc_unpack    = g;
  endfunction : scgc_unpack

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  scgc_regs_type    regs_q;
  scgc_regs_type    regs_d;
  scgc_apb_req_type req;
  logic [31:0]      wr_gate;
  logic             sleep_sync1_q;
  logic             sleep_sync2_q;
  logic             in_sleep;

  assign req.paddr   = PADDR;
  assign req.psel    = PSEL;
  assign req.penable = PENABLE;
  assign req.pwrite  = PWRITE;
  assign req.pwdata  = PWDATA;

  // Sleep request comes from the power controller outside this domain.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      sleep_sync1_q <= 1'b0;
      sleep_sync2_q <= 1'b0;
    end else if (CLK_EN) begin
      sleep_sync1_q <= SLEEP_REQ;
      sleep_sync2_q <= sleep_sync1_q;
    end
  end

  assign in_sleep = sleep_sync2_q;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    regs_d  = regs_q;
    wr_gate = scgc_mask_gate(req.pwdata);
    // A rate above the supported maximum is clamped rather than trusted.
    if (wr_gate[`SCGC_RATE_HI:`SCGC_RATE_LO] > RATE_MAX) begin
      wr_gate[`SCGC_RATE_HI:`SCGC_RATE_LO] = RATE_MAX;
    end
    case (regs_q.state)
      SCGC_IDLE: begin
        if (req.psel && !req.penable) begin
          regs_d.state = SCGC_ACCESS;
        end
      end
      SCGC_ACCESS: begin
        regs_d.state  = SCGC_DONE;
        regs_d.slverr = 1'b0;
        regs_d.rdata  = 32'h0000_0000;
        case (req.paddr)
          `SCGC_RUN_GATE_OFF: begin
            if (req.pwrite) begin
              regs_d.run_gate = wr_gate;
            end
            regs_d.rdata = regs_q.run_gate;
          end
          `SCGC_SLEEP_GATE_OFF: begin
            if (req.pwrite) begin
              regs_d.sleep_gate = wr_gate;
            end
            regs_d.rdata = regs_q.sleep_gate;
          end
          `SCGC_CLK_CFG_OFF: begin
            if (req.pwrite) begin
              regs_d.clk_cfg = req.pwdata & `SCGC_CLK_CFG_WMASK;
            end
            regs_d.rdata = regs_q.clk_cfg;
          end
          default: begin
            regs_d.slverr = 1'b1;
          end
        endcase
      end
      SCGC_DONE: begin
        regs_d.state = SCGC_IDLE;
        if (req.psel && !req.penable) begin
          regs_d.state = SCGC_ACCESS;
        end
      end
      default: begin
        regs_d.state = SCGC_IDLE;
      end
    endcase
    // Sleep values apply only when automatic gating is selected.
    if (in_sleep && regs_q.clk_cfg[`SCGC_AUTO_GATE_BIT]) begin
      regs_d.gate = scgc_unpack(regs_q.sleep_gate);
    end else begin
      regs_d.gate = scgc_unpack(regs_q.run_gate);
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      regs_q.run_gate   <= `SCGC_GATE_RESET;
      regs_q.sleep_gate <= `SCGC_GATE_RESET;
      regs_q.clk_cfg    <= `SCGC_CLK_CFG_RESET;
      regs_q.gate       <= '{sampler_en: 1'b0, sampler_rate: 2'h0,
                             hib_en: 1'b1, wdog_en: 1'b0};
      regs_q.rdata      <= 32'h0000_0000;
      regs_q.slverr     <= 1'b0;
      regs_q.state      <= SCGC_IDLE;
    end else if (CLK_EN) begin
      regs_q <= regs_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign PRDATA         = regs_q.rdata;
  assign PREADY         = (regs_q.state == SCGC_DONE);
  assign PSLVERR        = (regs_q.state == SCGC_DONE) && regs_q.slverr;
  assign SAMPLER_CLK_EN = regs_q.gate.sampler_en;
  assign SAMPLER_RATE   = regs_q.gate.sampler_rate;
  assign HIB_CLK_EN     = regs_q.gate.hib_en;
  assign WDOG_CLK_EN    = regs_q.gate.wdog_en;
  // The fault is combinational so the gated unit's bus answer can use it in-cycle.
  assign SAMPLER_FAULT  = SAMPLER_ACCESS && !regs_q.gate.sampler_en;
  assign WDOG_FAULT     = WDOG_ACCESS && !regs_q.gate.wdog_en;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  AST_RESET_VALUE: assert property ($fell(SRST) |->
      regs_q.sleep_gate == `SCGC_GATE_RESET && regs_q.run_gate == `SCGC_GATE_RESET)
    else $error("gating register reset value wrong");
  AST_RESERVED_ZERO: assert property (PREADY && !PSLVERR |->
      (PRDATA & ~(`SCGC_GATE_WMASK | `SCGC_CLK_CFG_WMASK)) == 32'h0000_0000)
    else $error("reserved bits read nonzero");
  AST_SLEEP_WRITE: assert property (CLK_EN && regs_q.state == SCGC_ACCESS && PWRITE
      && PADDR == `SCGC_SLEEP_GATE_OFF |=> regs_q.sleep_gate[`SCGC_HIB_BIT]
      == $past(PWDATA[`SCGC_HIB_BIT]))
    else $error("sleep register write lost");
  AST_RUN_WRITE: assert property (CLK_EN && regs_q.state == SCGC_ACCESS && PWRITE
      && PADDR == `SCGC_RUN_GATE_OFF |=> regs_q.run_gate[`SCGC_WDOG_BIT]
      == $past(PWDATA[`SCGC_WDOG_BIT]))
    else $error("run register write lost");
  AST_SLEEP_APPLY: assert property (CLK_EN && in_sleep && regs_q.clk_cfg[`SCGC_AUTO_GATE_BIT]
      |=> HIB_CLK_EN == $past(regs_q.sleep_gate[`SCGC_HIB_BIT]))
    else $error("sleep enables not applied");
  AST_RUN_APPLY: assert property (CLK_EN && !regs_q.clk_cfg[`SCGC_AUTO_GATE_BIT]
      |=> WDOG_CLK_EN == $past(regs_q.run_gate[`SCGC_WDOG_BIT]))
    else $error("run enables not kept without auto gating");
  AST_SAMPLER_MAP: assert property (CLK_EN && !in_sleep
      |=> SAMPLER_CLK_EN == $past(regs_q.run_gate[`SCGC_SAMPLER_BIT]))
    else $error("sampler enable not from bit 16");
  AST_RATE_MAP: assert property (CLK_EN && !in_sleep
      |=> SAMPLER_RATE == $past(regs_q.run_gate[`SCGC_RATE_HI:`SCGC_RATE_LO]))
    else $error("rate field not from bits 9:8");
  AST_FAULT: assert property (WDOG_ACCESS && !WDOG_CLK_EN |-> WDOG_FAULT)
    else $error("watchdog access to unclocked unit not faulted");
  AST_READY_ONE: assert property (PREADY |=> !PREADY)
    else $error("pready held beyond one cycle");

  // ---------------------------------------------------------------------------
  // Field mapping and bus assertions
  // ---------------------------------------------------------------------------
  // Each enable is checked against its own bit in both the run and the sleep
  // register, so a swapped bit position cannot hide behind one shared check.
  AST_HIB_MAP: assert property (
      CLK_EN && !in_sleep |=> HIB_CLK_EN == $past(regs_q.run_gate[`SCGC_HIB_BIT]))
    else $error("hibernate enable not from bit 6");

  AST_WDOG_MAP: assert property (
      CLK_EN && !in_sleep |=> WDOG_CLK_EN == $past(regs_q.run_gate[`SCGC_WDOG_BIT]))
    else $error("watchdog enable not from bit 3");

  AST_SLEEP_SAMPLER: assert property (
      CLK_EN && in_sleep && regs_q.clk_cfg[`SCGC_AUTO_GATE_BIT]
      |=> SAMPLER_CLK_EN == $past(regs_q.sleep_gate[`SCGC_SAMPLER_BIT]))
    else $error("sleep sampler enable not applied");

  AST_SLEEP_WDOG: assert property (
      CLK_EN && in_sleep && regs_q.clk_cfg[`SCGC_AUTO_GATE_BIT]
      |=> WDOG_CLK_EN == $past(regs_q.sleep_gate[`SCGC_WDOG_BIT]))
    else $error("sleep watchdog enable not applied");

  AST_SLEEP_RATE: assert property (
      CLK_EN && in_sleep && regs_q.clk_cfg[`SCGC_AUTO_GATE_BIT]
      |=> SAMPLER_RATE == $past(regs_q.sleep_gate[`SCGC_RATE_HI:`SCGC_RATE_LO]))
    else $error("sleep rate field not applied");

  AST_SLEEP_NO_AUTO: assert property (
      CLK_EN && in_sleep && !regs_q.clk_cfg[`SCGC_AUTO_GATE_BIT]
      |=> HIB_CLK_EN == $past(regs_q.run_gate[`SCGC_HIB_BIT]))
    else $error("sleep register used without auto gating");

  AST_RESERVED_SLEEP: assert property (
      (regs_q.sleep_gate & ~`SCGC_GATE_WMASK) == 32'h0000_0000)
    else $error("sleep register reserved bit set");

  AST_RESERVED_RUN: assert property (
      (regs_q.run_gate & ~`SCGC_GATE_WMASK) == 32'h0000_0000)
    else $error("run register reserved bit set");

  AST_RATE_LIMIT: assert property (
      regs_q.sleep_gate[`SCGC_RATE_HI:`SCGC_RATE_LO] <= RATE_MAX
      && regs_q.run_gate[`SCGC_RATE_HI:`SCGC_RATE_LO] <= RATE_MAX)
    else $error("rate field above supported maximum");

  AST_UNMAPPED_KEEP: assert property (
      CLK_EN && regs_q.state == SCGC_ACCESS && PADDR != `SCGC_RUN_GATE_OFF
      && PADDR != `SCGC_SLEEP_GATE_OFF && PADDR != `SCGC_CLK_CFG_OFF
      |=> $stable(regs_q.run_gate) && $stable(regs_q.sleep_gate) && PSLVERR)
    else $error("unmapped access not refused");

  AST_FREEZE: assert property (
      !CLK_EN |=> $stable(regs_q))
    else $error("state moved while clock enable low");

  AST_SAMPLER_FAULT: assert property (
      SAMPLER_ACCESS && !SAMPLER_CLK_EN |-> SAMPLER_FAULT)
    else $error("sampler access to unclocked unit not faulted");

  AST_WDOG_NO_FAULT: assert property (
      WDOG_CLK_EN |-> !WDOG_FAULT)
    else $error("watchdog faulted while clocked");

  AST_SAMPLER_NO_FAULT: assert property (
      SAMPLER_CLK_EN |-> !SAMPLER_FAULT)
    else $error("sampler faulted while clocked");

  AST_READY_TIMING: assert property (
      CLK_EN && regs_q.state == SCGC_ACCESS |=> PREADY)
    else $error("access phase not answered in the next cycle");

  AST_RESET_OUTPUTS: assert property (
      $fell(SRST) |-> HIB_CLK_EN && !SAMPLER_CLK_EN && !WDOG_CLK_EN
      && SAMPLER_RATE == 2'h0)
    else $error("enable outputs wrong after reset");

  AST_SLEEP_READ: assert property (
      CLK_EN && regs_q.state == SCGC_ACCESS && !PWRITE && PADDR == `SCGC_SLEEP_GATE_OFF
      |=> PRDATA == $past(regs_q.sleep_gate))
    else $error("sleep register read wrong");

  AST_RUN_READ: assert property (
      CLK_EN && regs_q.state == SCGC_ACCESS && !PWRITE && PADDR == `SCGC_RUN_GATE_OFF
      |=> PRDATA == $past(regs_q.run_gate))
    else $error("run register read wrong");

  AST_CFG_READ: assert property (
      CLK_EN && regs_q.state == SCGC_ACCESS && !PWRITE && PADDR == `SCGC_CLK_CFG_OFF
      |=> PRDATA == $past(regs_q.clk_cfg))
    else $error("clock config read wrong");

  AST_CFG_WRITE: assert property (
      CLK_EN && regs_q.state == SCGC_ACCESS && PWRITE && PADDR == `SCGC_CLK_CFG_OFF
      |=> regs_q.clk_cfg[`SCGC_AUTO_GATE_BIT] == $past(PWDATA[`SCGC_AUTO_GATE_BIT]))
    else $error("auto gate select write lost");

  AST_CFG_MASK: assert property (
      (regs_q.clk_cfg & ~`SCGC_CLK_CFG_WMASK) == 32'h0000_0000)
    else $error("clock config reserved bit set");

  AST_ERR_WITH_READY: assert property (
      PSLVERR |-> PREADY)
    else $error("error raised outside the answer cycle");

  AST_ERR_ZERO_DATA: assert property (
      PSLVERR |-> PRDATA == 32'h0000_0000)
    else $error("refused access returned data");

  AST_IDLE_QUIET: assert property (
      regs_q.state == SCGC_IDLE |-> !PREADY && !PSLVERR)
    else $error("answer while idle");

  AST_DONE_IDLE: assert property (
      CLK_EN && regs_q.state == SCGC_DONE && !(PSEL && !PENABLE)
      |=> regs_q.state == SCGC_IDLE)
    else $error("answer cycle not followed by idle");

  AST_STATE_ONEHOT: assert property (
      $onehot(regs_q.state))
    else $error("bus state not one-hot");

  COV_SLEEP_AUTO: cover property (in_sleep && regs_q.clk_cfg[`SCGC_AUTO_GATE_BIT]);
  COV_FAULT:      cover property (SAMPLER_FAULT);
  COV_SLVERR:     cover property (PSLVERR);
  COV_RATE_CLAMP: cover property (regs_q.state == SCGC_ACCESS && PWRITE
      && PWDATA[`SCGC_RATE_HI:`SCGC_RATE_LO] == 2'h3);

endmodule : scgc_gate_ctrl
`default_nettype wire

// file: tb/scgc_unit_model.sv
// Model of the gated units that aim bus accesses at the sampler and the watchdog.
`default_nettype none
module scgc_unit_model (
  input  wire logic       MCLK,
  input  wire logic [1:0] sel,
  output var  logic       smp_acc,
  output var  logic       wdg_acc
);
  timeunit 1ns;
  timeprecision 1ns;
  // A unit raises its access one edge after the request, as its own bus would.
  always_ff @(posedge MCLK) begin
    smp_acc <= sel[0];
    wdg_acc <= sel[1];
  end
endmodule : scgc_unit_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking testbench of the clock gating register block.
`default_nettype none
`include "scgc_params.svh"
module tb
  import scgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        MCLK = 1'b0, SRST = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        sleep = 1'b0, ce = 1'b1, PREADY, PSLVERR, smp_en, hib_en, wdg_en;
  logic        smp_acc, wdg_acc, smp_f, wdg_f, e;
  logic [1:0]  sel = 2'h0, rate;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, PRDATA, r, d, rv, sv;
  int          err_total = 0, checks = 0, seed = 32'h7006_3626;

  scgc_gate_ctrl DUT (.MCLK(MCLK), .SRST(SRST), .CLK_EN(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SLEEP_REQ(sleep),
    .SAMPLER_ACCESS(smp_acc), .WDOG_ACCESS(wdg_acc), .SAMPLER_CLK_EN(smp_en),
    .SAMPLER_RATE(rate), .HIB_CLK_EN(hib_en), .WDOG_CLK_EN(wdg_en),
    .SAMPLER_FAULT(smp_f), .WDOG_FAULT(wdg_f));
  scgc_unit_model PEER (.MCLK(MCLK), .sel(sel), .smp_acc(smp_acc), .wdg_acc(wdg_acc));

  initial begin
    forever #50 MCLK = ~MCLK;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic end_of_test;
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Writable bits only; a rate code above the top one is held at the top one.
  function automatic logic [31:0] masked(input logic [31:0] v);
    logic [31:0] m;
    m = v & `SCGC_GATE_WMASK;
    if (m[9:8] == 2'h3) m[9:8] = `SCGC_RATE_MAX_RESET;
    return m;
  endfunction : masked

  task automatic outs(input logic [31:0] m);
    chk({27'h0, smp_en, rate, hib_en, wdg_en}, {27'h0, m[16], m[9:8], m[6], m[3]});
  endtask : outs

  // Entered just after a rising edge; returns just after a rising edge, bus idle.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge MCLK);
    penable <= 1'b1;
    @(posedge MCLK);
    while (PREADY !== 1'b1 && n < 20) begin
      n++;
      @(posedge MCLK);
    end
    if (n == 20) begin
      err_total++;
      end_of_test();
    end
    rd = PRDATA;
    er = PSLVERR;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge MCLK);
  endtask : apb

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge MCLK);
    SRST <= 1'b0;
    @(negedge MCLK);
    outs(`SCGC_GATE_RESET);
    @(posedge MCLK);
    ce <= 1'b0;
    repeat (3) @(posedge MCLK);
    @(negedge MCLK);
    outs(`SCGC_GATE_RESET);
    @(posedge MCLK);
    ce <= 1'b1;
    @(posedge MCLK);
    apb(1'b0, 12'h110, 32'h0000_0000, r, e);
    chk(r, `SCGC_GATE_RESET);
    apb(1'b0, 12'h100, 32'h0000_0000, r, e);
    chk(r, `SCGC_GATE_RESET);
    apb(1'b1, 12'h104, 32'hFFFF_FFFF, r, e);
    chk({31'h0, e}, 32'h0000_0001);
    rv = `SCGC_GATE_RESET;
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
      apb(1'b1, 12'h100, d, r, e);
      sel <= i[1:0];
      @(negedge MCLK);
      outs(masked(d));
      @(posedge MCLK);
      @(negedge MCLK);
      chk({30'h0, smp_f, wdg_f}, {30'h0, i[0] & ~d[16], i[1] & ~d[3]});
      @(posedge MCLK);
      apb(1'b0, 12'h100, 32'h0000_0000, r, e);
      chk(r, masked(d));
      rv = masked(d);
    end
    apb(1'b0, 12'h110, 32'h0000_0000, r, e);
    d = $random(seed);
    apb(1'b1, 12'h110, r | d, r, e);
    sv = masked(`SCGC_GATE_RESET | d);
    sleep <= 1'b1;
    repeat (6) @(posedge MCLK);
    @(negedge MCLK);
    outs(rv);
    @(posedge MCLK);
    apb(1'b1, 12'h060, 32'hFFFF_FFFF, r, e);
    apb(1'b0, 12'h060, 32'h0000_0000, r, e);
    chk(r, 32'h0800_0000);
    repeat (5) @(posedge MCLK);
    @(negedge MCLK);
    outs(sv);
    @(posedge MCLK);
    sleep <= 1'b0;
    repeat (6) @(posedge MCLK);
    @(negedge MCLK);
    outs(rv);
    @(posedge MCLK);
    SRST <= 1'b1;
    repeat (2) @(posedge MCLK);
    SRST <= 1'b0;
    @(negedge MCLK);
    outs(`SCGC_GATE_RESET);
    @(posedge MCLK);
    apb(1'b0, 12'h110, 32'h0000_0000, r, e);
    chk(r, `SCGC_GATE_RESET);
    end_of_test();
  end

  initial begin
    #2_000_000;
    err_total++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
